// [common/adc_seq_consts.vh]
// constants for the converter mode sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
// register offsets (4-bit address)
`define REG_CTRL 4'h0
`define REG_CFG 4'h1
`define REG_STATUS 4'h2
`define REG_MASK 4'h3
`define REG_RESULT0 4'h8
// control register fields
`define CTRL_START 0
`define CTRL_TRIG_EXT 1
`define CTRL_OPAMP 2
// config register fields
`define CFG_MODE_LO 0
`define CFG_MODE_HI 2
`define CFG_GRP_LO 3
`define CFG_GRP_HI 4
`define CFG_CH_LO 5
`define CFG_CH_HI 7
`define CFG_DIV_LO 8
`define CFG_DIV_HI 9
`define CFG_RES10 10
`define CFG_SH 11
`define CFG_RESET 12'h400
// modes
`define MODE_ONESHOT 3'h0
`define MODE_REPEAT 3'h1
`define MODE_SWEEP 3'h2
`define MODE_RSWEEP0 3'h3
`define MODE_RSWEEP1 3'h4
// clock divide codes
`define DIV_4 2'h0
`define DIV_2 2'h1
// conversion lengths in conversion-clock cycles
`define CYC_SH_10 7'd33
`define CYC_SH_8 7'd28
`define CYC_NSH_10 7'd59
`define CYC_NSH_8 7'd49
// status bits
`define ST_CONV_DONE 0
`define ST_SWEEP_DONE 1
`endif

// [src/adc_conv_timer.v]
// conversion-clock divider and conversion length counter
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_conv_timer (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // control
    input wire i_run,
    input wire [1:0] i_div_sel,
    input wire i_res10,
    input wire i_sh,
    // done pulse after the full conversion length
    output reg o_done
);
    reg [1:0] pre_q;
    reg [6:0] cnt_q;
    reg [6:0] len;
    reg tick;
    always @* begin
        if (i_sh) begin
            len = i_res10 ? `CYC_SH_10 : `CYC_SH_8;
        end else begin
            len = i_res10 ? `CYC_NSH_10 : `CYC_NSH_8;
        end
        case (i_div_sel)
            `DIV_4: tick = (pre_q == 2'h3);
            `DIV_2: tick = pre_q[0];
            default: tick = 1'b1;
        endcase
    end
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_q <= 2'h0;
            cnt_q <= 7'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (!i_run) begin
                pre_q <= 2'h0;
                cnt_q <= 7'h00;
            end else begin
                pre_q <= pre_q + 2'h1;
                if (tick) begin
                    if (cnt_q == len - 7'h01) begin
                        cnt_q <= 7'h00;
                        o_done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 7'h01;
                    end
                end
            end
        end
    end
endmodule // adc_conv_timer
`default_nettype wire

// [src/adc_mode_sequencer.v]
// mode sequencer for an eight-channel successive-approximation converter
// Functional notes
// - Op-amp one-shot routes the chosen channel to the expansion output and converts the expansion input.
// - Op-amp one-shot stores its result in the chosen channel register and raises the interrupt request.
// - Repeat mode converts the chosen channel and stores each result without interrupt request.
// - Repeat mode keeps converting the same channel until software clears start.
// - Single sweep converts channel 0 then each group channel, storing each result at once.
// - Single sweep ends with interrupt request, start cleared and converter halted.
// - Repeat sweep 0 loops over the group from channel 0 with no interrupt request.
// - Repeating modes stop only when software writes zero to start.
// - Sweep group is channels 0-1, 0-3, 0-5 or 0-7.
// - Repeat sweep 1 priority group is channel 0, 0-1, 0-2 or 0-3.
// - Conversion clock is source divided by four, two or one.
// - One conversion lasts 33/28 cycles with sample and hold, 59/49 without.
// - External trigger falling edge starts, and restarts a running conversion.
// - Repeat sweep 1 inserts one rotating non-priority channel after each priority pass.
// - Plain one-shot stores and raises interrupt request, then clears start and stops, or under external trigger keeps start and waits for the next edge.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_mode_sequencer #(
    parameter NCH = 8
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // register port
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // analog core
    output reg o_conv_start,
    output reg [2:0] o_chan_sel,
    output reg o_expansion_output_en,
    output reg o_sample_expansion_input,
    input wire i_conv_done,
    input wire [9:0] i_conv_result,
    // external trigger pin
    input wire i_external_trigger_pin,
    // interrupt
    output reg o_irq
);
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_CONV = 2'h2;

    reg [2:0] ctrl_q;
    reg [11:0] cfg_q;
    reg [1:0] status_q;
    reg [1:0] mask_q;
    reg [9:0] result_q [0:NCH-1];
    reg [1:0] state_q;
    reg [2:0] chan_q;
    reg [2:0] extra_q;
    reg trg_m_q;
    reg trg_s_q;
    reg trg_p_q;
    wire tmr_done;

    wire [2:0] mode = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];
    wire [1:0] grp = cfg_q[`CFG_GRP_HI:`CFG_GRP_LO];
    wire [2:0] sel_ch = cfg_q[`CFG_CH_HI:`CFG_CH_LO];
    wire start_f = ctrl_q[`CTRL_START];
    wire trig_ext = ctrl_q[`CTRL_TRIG_EXT];
    wire opamp = ctrl_q[`CTRL_OPAMP];
    wire sweep_mode = (mode == `MODE_SWEEP) || (mode == `MODE_RSWEEP0) ||
        (mode == `MODE_RSWEEP1);
    wire [2:0] sweep_last = {grp, 1'b1};
    wire [2:0] prio_last = {1'b0, grp};
    wire trig_fall = trg_p_q & ~trg_s_q;
    wire conv_end = (state_q == S_CONV) && i_conv_done && tmr_done;
    wire wr_ctrl = i_wr && (i_addr == `REG_CTRL);
    wire sw_stop = wr_ctrl && !i_wdata[`CTRL_START];
    wire rd_status = i_rd && (i_addr == `REG_STATUS);

    // timer gates completion to the documented conversion length
    adc_conv_timer u_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_run(state_q == S_CONV && !(trig_ext && trig_fall)),
        .i_div_sel(cfg_q[`CFG_DIV_HI:`CFG_DIV_LO]),
        .i_res10(cfg_q[`CFG_RES10]),
        .i_sh(cfg_q[`CFG_SH]),
        .o_done(tmr_done)
    );

    // next channel and end-of-pass decision
    reg [2:0] next_ch;
    reg [2:0] next_extra;
    reg pass_end;
    always @* begin
        next_ch = chan_q;
        next_extra = extra_q;
        pass_end = 1'b0;
        case (mode)
            `MODE_SWEEP, `MODE_RSWEEP0: begin
                pass_end = (chan_q == sweep_last);
                next_ch = pass_end ? 3'h0 : chan_q + 3'h1;
            end
            `MODE_RSWEEP1: begin
                if (chan_q == prio_last) begin
                    next_ch = extra_q;
                end else if (chan_q < prio_last) begin
                    next_ch = chan_q + 3'h1;
                end else begin
                    next_ch = 3'h0;
                    next_extra = (extra_q == 3'h7) ? prio_last + 3'h1 : extra_q + 3'h1;
                end
            end
            default: begin
                next_ch = sel_ch;
            end
        endcase
    end

    // pin synchroniser
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trg_m_q <= 1'b1;
            trg_s_q <= 1'b1;
            trg_p_q <= 1'b1;
        end else begin
            trg_m_q <= i_external_trigger_pin;
            trg_s_q <= trg_m_q;
            trg_p_q <= trg_s_q;
        end
    end

    // result registers
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_res
            always @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    result_q[g] <= 10'h000;
                end else if (conv_end && !sw_stop && chan_q == g) begin
                    result_q[g] <= i_conv_result;
                end
            end
        end
    endgenerate

    // sequencer, control and status
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= 3'h0;
            cfg_q <= `CFG_RESET;
            mask_q <= 2'h0;
            status_q <= 2'h0;
            state_q <= S_IDLE;
            chan_q <= 3'h0;
            extra_q <= 3'h0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            if (wr_ctrl) begin
                ctrl_q <= i_wdata[2:0];
            end
            if (i_wr && i_addr == `REG_CFG) begin
                cfg_q <= i_wdata[11:0];
            end
            if (i_wr && i_addr == `REG_MASK) begin
                mask_q <= i_wdata[1:0];
            end
            if (rd_status) begin
                status_q <= 2'h0;
            end
            if (sw_stop) begin
                state_q <= S_IDLE;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (wr_ctrl && i_wdata[`CTRL_START]) begin
                            chan_q <= sweep_mode ? 3'h0 : sel_ch;
                            extra_q <= prio_last + 3'h1;
                            if (i_wdata[`CTRL_TRIG_EXT]) begin
                                state_q <= S_WAIT;
                            end else begin
                                state_q <= S_CONV;
                                o_conv_start <= 1'b1;
                            end
                        end
                    end
                    S_WAIT: begin
                        if (trig_fall) begin
                            state_q <= S_CONV;
                            o_conv_start <= 1'b1;
                        end
                    end
                    S_CONV: begin
                        if (trig_ext && trig_fall) begin
                            chan_q <= sweep_mode ? 3'h0 : sel_ch;
                            extra_q <= prio_last + 3'h1;
                            o_conv_start <= 1'b1;
                        end else if (conv_end) begin
                            chan_q <= next_ch;
                            extra_q <= next_extra;
                            if (mode == `MODE_ONESHOT) begin
                                status_q[`ST_CONV_DONE] <= 1'b1;
                                state_q <= trig_ext ? S_WAIT : S_IDLE;
                                if (!trig_ext) begin
                                    ctrl_q[`CTRL_START] <= 1'b0;
                                end
                            end else if (mode == `MODE_SWEEP && pass_end) begin
                                status_q[`ST_SWEEP_DONE] <= 1'b1;
                                ctrl_q[`CTRL_START] <= 1'b0;
                                state_q <= S_IDLE;
                            end else begin
                                o_conv_start <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // outputs and read port
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
            o_irq <= 1'b0;
            o_chan_sel <= 3'h0;
            o_expansion_output_en <= 1'b0;
            o_sample_expansion_input <= 1'b0;
        end else begin
            o_irq <= |(status_q & mask_q);
            o_chan_sel <= chan_q;
            o_expansion_output_en <= opamp && mode == `MODE_ONESHOT && state_q != S_IDLE;
            o_sample_expansion_input <= opamp && mode == `MODE_ONESHOT;
            o_rdata <= 16'h0000;
            if (i_rd) begin
                if (i_addr[3]) begin
                    o_rdata <= {6'h00, result_q[i_addr[2:0]]};
                end else begin
                    case (i_addr)
                        `REG_CTRL: o_rdata <= {13'h0000, ctrl_q};
                        `REG_CFG: o_rdata <= {4'h0, cfg_q};
                        `REG_STATUS: o_rdata <= {12'h000, state_q, status_q};
                        `REG_MASK: o_rdata <= {14'h0000, mask_q};
                        default: o_rdata <= 16'h0000;
                    endcase
                end
            end
        end
    end
endmodule // adc_mode_sequencer
`default_nettype wire

// [bench/adc_seq_props.sv]
// port checker for the converter mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_seq_props (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // register port
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    // core, pins, interrupt
    input wire o_conv_start,
    input wire [2:0] o_chan_sel,
    input wire o_expansion_output_en,
    input wire o_sample_expansion_input,
    input wire i_conv_done,
    input wire [9:0] i_conv_result,
    input wire i_external_trigger_pin,
    input wire o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire ctrl_wr = i_wr && i_addr == `REG_CTRL;
    wire mask_wr = i_wr && i_addr == `REG_MASK;
    wire src = i_conv_done || mask_wr;
    wire clr = (i_rd && i_addr == `REG_STATUS) || mask_wr;
    reg [5:0] gap_q;
    // cycles since last start, parked at 63 after control writes or trigger
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) gap_q <= 6'h3f;
        else if (ctrl_wr || !i_external_trigger_pin) gap_q <= 6'h3f;
        else if (o_conv_start) gap_q <= 6'h00;
        else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
    end
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start strobe longer than one cycle");
    a_stop_quiet: assert property (ctrl_wr && !i_wdata[0] |=> (!o_conv_start || $past(ctrl_wr && i_wdata[0])) [*8])
        else $error("start strobe after stop");
    a_opamp_pair: assert property (o_expansion_output_en |-> o_sample_expansion_input)
        else $error("expansion output without expansion input");
    a_conv_gap: assert property (o_conv_start |-> gap_q >= 6'h1b)
        else $error("conversion shorter than minimum");
    a_irq_fall: assert property ($fell(o_irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
        else $error("interrupt fell without clear");
    a_irq_rise: assert property ($rose(o_irq) |-> $past(src) || $past(src, 2) || $past(src, 3))
        else $error("interrupt rose without cause");
    a_chan_hold: assert property (o_conv_start |=> ##1 $stable(o_chan_sel) [*8])
        else $error("channel moved during conversion");
    cover property ($rose(o_irq));
    cover property (o_expansion_output_en);
    cover property (ctrl_wr && !i_wdata[0]);
endmodule // adc_seq_props
`default_nettype wire

// [bench/adc_core_model.sv]
// behavioural analog converter core
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // from sequencer
    input wire logic i_conv_start,
    // to sequencer
    output logic o_conv_done,
    output logic [9:0] o_conv_result
);
    logic [9:0] val_q;
    logic busy_q;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_q <= 1'b0;
            val_q <= 10'h0a5;
        end else if (i_conv_start) begin
            busy_q <= 1'b1;
            val_q <= val_q * 10'h005 + 10'h0c7;
        end
    end
    // done held high so the timer decides; idle result is inverted
    assign o_conv_done = busy_q;
    assign o_conv_result = busy_q ? val_q : ~val_q;
endmodule // adc_core_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the converter mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module tb;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_external_trigger_pin = 1'b1;
    wire [15:0] o_rdata;
    wire o_conv_start, o_expansion_output_en, o_sample_expansion_input, o_irq, done;
    wire [2:0] o_chan_sel;
    wire [9:0] res;
    int n_errors = 0;
    int total_checks = 0;
    int chq[$];
    int k, g, c, n;
    logic pend = 1'b0;
    logic [31:0] rs = 32'h6e46ef34;
    logic [15:0] rv, r0;
    logic [15:0] ctl [3] = '{16'h0001, 16'h0005, 16'h0003};
    always #5 i_clk = ~i_clk;
    adc_mode_sequencer adc_mode_sequencer_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_conv_start(o_conv_start), .o_chan_sel(o_chan_sel),
        .o_expansion_output_en(o_expansion_output_en),
        .o_sample_expansion_input(o_sample_expansion_input), .i_conv_done(done),
        .i_conv_result(res), .i_external_trigger_pin(i_external_trigger_pin), .o_irq(o_irq));
    adc_core_model adc_core_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_conv_start(o_conv_start), .o_conv_done(done), .o_conv_result(res));
    // channel stands the cycle after the start strobe
    always @(posedge i_clk) begin
        if (pend) chq.push_back(o_chan_sel);
        pend <= o_conv_start;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int ech(input int m, input int g, input int ch, input int i);
        if (m < 2) return ch;
        if (m < 4) return i % (2 * g + 2);
        if (i % (g + 2) <= g) return i % (g + 2);
        return g + 1 + (i / (g + 2)) % (7 - g);
    endfunction
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic wirq();
        int i;
        for (i = 0; i < 1000 && o_irq !== 1'b1; i++) @(posedge i_clk);
        chk("irq_up", o_irq, 1'b1);
    endtask
    task automatic seq(input int m, input int g, input int ch, input int n);
        int i;
        rs = xs(rs);
        chq.delete();
        wr(`REG_CFG, 16'(m + (g << 3) + (ch << 5)) | {rs[11:8], 8'h00});
        wr(`REG_CTRL, 16'h0001);
        for (i = 0; i < 3000 && chq.size() < n; i++) @(posedge i_clk);
        for (i = 0; i < n; i++) chk("chan", 16'(chq[i]), 16'(ech(m, g, ch, i)));
        if (m != 2) chk("no_irq", o_irq, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #900000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(`REG_CFG);
        chk("cfg_reset", rv, `CFG_RESET);
        rd(`REG_STATUS);
        chk("st_reset", rv, 16'h0000);
        rd(4'h5);
        chk("unmapped", rv, 16'h0000);
        wr(`REG_MASK, 16'h0003);
        for (k = 0; k < 3; k++) begin
            rs = xs(rs);
            c = rs[2:0];
            chq.delete();
            wr(`REG_CFG, 16'h0f00 | 16'(c << 5));
            wr(`REG_CTRL, ctl[k]);
            if (k == 2) begin
                repeat (40) @(posedge i_clk);
                chk("no_trig", 16'(chq.size()), 16'h0000);
                i_external_trigger_pin <= 1'b0;
            end
            repeat (8) @(posedge i_clk);
            chk("exp_out", o_expansion_output_en, k == 1);
            chk("exp_in", o_sample_expansion_input, k == 1);
            wirq();
            chk("chan", 16'(chq[0]), 16'(c));
            rd(`REG_RESULT0 + 4'(c));
            chk("result", rv, 16'(adc_core_model_i.val_q));
            rd(`REG_STATUS);
            chk("done_bit", rv & 16'h0003, 16'h0001);
            rd(`REG_CTRL);
            if (k != 1) chk("start", rv[0], k == 2);
            i_external_trigger_pin <= 1'b1;
            wr(`REG_CTRL, 16'h0000);
            chk("irq_clr", o_irq, 1'b0);
            $display("one-shot case %0d done", k);
        end
        for (g = 0; g < 4; g++) begin
            seq(`MODE_SWEEP, g, 0, 2 * g + 2);
            wirq();
            chk("sweep_n", 16'(chq.size()), 16'(2 * g + 2));
            rd(`REG_STATUS);
            chk("sweep_bit", rv & 16'h0003, 16'h0002);
            rd(`REG_CTRL);
            chk("sweep_stop", rv[0], 1'b0);
            rd(`REG_RESULT0 + 4'(2 * g + 1));
            chk("sweep_res", rv, 16'(adc_core_model_i.val_q));
        end
        wr(`REG_MASK, 16'h0001);
        seq(`MODE_SWEEP, 0, 0, 2);
        repeat (300) @(posedge i_clk);
        chk("masked", o_irq, 1'b0);
        wr(`REG_MASK, 16'h0003);
        repeat (3) @(posedge i_clk);
        chk("unmasked", o_irq, 1'b1);
        rd(`REG_STATUS);
        $display("sweep done");
        seq(`MODE_RSWEEP0, 1, 0, 8);
        wr(`REG_CTRL, 16'h0000);
        seq(`MODE_RSWEEP1, 1, 0, 12);
        wr(`REG_CTRL, 16'h0000);
        seq(`MODE_RSWEEP1, 3, 0, 10);
        wr(`REG_CTRL, 16'h0000);
        seq(`MODE_REPEAT, 0, 3, 4);
        wr(`REG_CTRL, 16'h0000);
        rd(`REG_RESULT0 + 4'h3);
        r0 = rv;
        n = chq.size();
        repeat (400) @(posedge i_clk);
        rd(`REG_RESULT0 + 4'h3);
        chk("abort_res", rv, r0);
        chk("stopped", 16'(chq.size()), 16'(n));
        $display("repeat modes done");
        tally_and_finish();
    end
endmodule // tb
bind adc_mode_sequencer adc_seq_props adc_seq_props_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_start(o_conv_start), .o_chan_sel(o_chan_sel),
    .o_expansion_output_en(o_expansion_output_en),
    .o_sample_expansion_input(o_sample_expansion_input), .i_conv_done(i_conv_done),
    .i_conv_result(i_conv_result), .i_external_trigger_pin(i_external_trigger_pin),
    .o_irq(o_irq));
`default_nettype wire
